//--- hdl/fbp_arr_if.sv
// Port bundle between the sequencer and the flash word array
`timescale 1ns/1ps
`include "fbp_consts.svh"

interface fbp_arr_if;
    logic                    ren;
    logic [`FBP_AW-1:0]      raddr;
    logic [`FBP_DW-1:0]      rdata;
    logic                    wen;
    logic [`FBP_AW-1:0]      waddr;
    logic [`FBP_DW-1:0]      wdata;

    modport ctrl (output ren, output raddr, input rdata, output wen, output waddr, output wdata);
    modport mem  (input ren, input raddr, output rdata, input wen, input waddr, input wdata);
endinterface

//--- hdl/fbp_array.sv
// Flash word array with one synchronous read and one write port
`timescale 1ns/1ps
`include "fbp_consts.svh"

module fbp_array #(
    parameter int unsigned WORDS = `FBP_WORDS
) (
    // Clock
    input wire logic   clk,
    // Sequencer side
    fbp_arr_if.mem     port
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // No reset: contents are nonvolatile
    logic [`FBP_DW-1:0] mem [WORDS];

    always_ff @(posedge clk) begin
        if (port.wen) begin
            mem[port.waddr] <= port.wdata;
        end
        if (port.ren) begin
            port.rdata <= mem[port.raddr];
        end
    end

endmodule

//--- hdl/fbp_consts.svh
// Constants for the flash block erase and protection controller
`ifndef FBP_CONSTS_SVH
`define FBP_CONSTS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FBP_FLASH_KB      96
`define FBP_BLOCK_BYTES   1024
`define FBP_WORD_BYTES    4
`define FBP_BLOCKS        96
`define FBP_UNITS         48
`define FBP_WORDS         24576
`define FBP_AW            15
`define FBP_DW            32
`define FBP_BLK_W         7
`define FBP_OFF_W         8
`define FBP_UNIT_W        6

// ----------------------------------------------------------------
// Field positions of a word address
// ----------------------------------------------------------------
`define FBP_BLK_LSB       8
`define FBP_UNIT_LSB      9
`define FBP_OFF_LAST      8'hff

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define FBP_ERASED_WORD   32'hffffffff
`define FBP_RST_DATA      32'h00000000
`define FBP_RST_ADDR      15'h0000

`endif

//--- hdl/fbp_ctrl.sv
// Flash sequencer: reads, word program and block erase under protection
// Function
// - 96 KB array in 1-KB blocks; erasing one block touches no other.
// - An erased block reads back all ones.
// - Protection per 2-KB unit of two blocks, read-only or execute-only.
// - Read-only unit refuses erase and program but still serves reads.
// - Execute-only unit refuses every erase and program.
// - Execute-only unit serves instruction fetch only; data and debug reads denied.
`timescale 1ns/1ps
`include "fbp_consts.svh"

module fbp_ctrl #(
    parameter int unsigned N_BLOCKS = `FBP_BLOCKS,
    parameter int unsigned N_UNITS  = `FBP_UNITS
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Read request and answer
    input  wire logic                     rd_req,
    input  wire fbp_pkg::fbp_src_t        rd_src,
    input  wire logic [`FBP_AW-1:0]       rd_addr,
    output logic                          rd_gnt,
    output logic                          rd_ack,
    output logic                          rd_denied,
    output logic [`FBP_DW-1:0]            rd_data,
    // Word program request
    input  wire logic                     pg_req,
    input  wire logic [`FBP_AW-1:0]       pg_addr,
    input  wire logic [`FBP_DW-1:0]       pg_data,
    output logic                          pg_gnt,
    // Block erase request
    input  wire logic                     er_req,
    input  wire logic [`FBP_BLK_W-1:0]    er_block,
    output logic                          er_gnt,
    // Completion of program and erase
    output logic                          op_done,
    output logic                          op_refused,
    output logic                          busy,
    // Protection per 2-KB unit
    input  wire logic [N_UNITS-1:0]       prot_ro,
    input  wire logic [N_UNITS-1:0]       prot_xo
);

    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    fbp_arr_if arr ();

    fbp_array #(
        .WORDS (N_BLOCKS * (`FBP_BLOCK_BYTES / `FBP_WORD_BYTES))
    ) u_array (
        .clk  (clk),
        .port (arr.mem)
    );

    // ------------------------------------------------------------
    // Protection decode
    // ------------------------------------------------------------
    logic [N_UNITS-1:0]       unit_lock;
    logic [`FBP_UNIT_W-1:0]   rd_unit;
    logic [`FBP_UNIT_W-1:0]   pg_unit;
    logic [`FBP_UNIT_W-1:0]   er_unit;
    logic                     rd_in;
    logic                     pg_in;
    logic                     er_in;
    logic                     rd_ok;
    logic                     pg_ok;
    logic                     er_ok;

    // Either mark blocks modification of the whole unit
    for (genvar i = 0; i < N_UNITS; i++) begin : g_unit
        assign unit_lock[i] = prot_ro[i] | prot_xo[i];
    end

    // Two adjacent blocks share one unit
    assign rd_unit = rd_addr[`FBP_AW-1:`FBP_UNIT_LSB];
    assign pg_unit = pg_addr[`FBP_AW-1:`FBP_UNIT_LSB];
    assign er_unit = er_block[`FBP_BLK_W-1:1];

    // Addresses past the array are refused like protected ones
    assign rd_in = 32'(rd_addr[`FBP_AW-1:`FBP_BLK_LSB]) < N_BLOCKS;
    assign pg_in = 32'(pg_addr[`FBP_AW-1:`FBP_BLK_LSB]) < N_BLOCKS;
    assign er_in = 32'(er_block) < N_BLOCKS;

    // Read-only never limits reads; execute-only admits fetch only
    assign rd_ok = rd_in
        && (!(rd_in && prot_xo[rd_unit]) || rd_src == fbp_pkg::FBP_SRC_FETCH);
    assign pg_ok = pg_in && !(pg_in && unit_lock[pg_unit]);
    assign er_ok = er_in && !(er_in && unit_lock[er_unit]);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    localparam fbp_pkg::fbp_ctrl_t RST_Q = '{
        st:      fbp_pkg::FBP_ST_IDLE,
        addr:    `FBP_RST_ADDR,
        data:    `FBP_RST_DATA,
        rd_ok:   1'b0,
        rd_ack:  1'b0,
        rd_err:  1'b0,
        rd_data: `FBP_RST_DATA,
        op_done: 1'b0,
        op_err:  1'b0
    };

    fbp_pkg::fbp_ctrl_t q_q;
    fbp_pkg::fbp_ctrl_t q_d;

    // ------------------------------------------------------------
    // Erase walk and read answer
    // ------------------------------------------------------------
    logic [`FBP_OFF_W-1:0]    er_off;
    logic [`FBP_OFF_W-1:0]    er_off_next;
    logic                     er_last;
    logic [`FBP_DW-1:0]       rd_word;

    // Offset wraps inside the block, so a neighbour is never touched
    assign er_off      = q_q.addr[`FBP_OFF_W-1:0];
    assign er_off_next = er_off + `FBP_OFF_W'(1);
    assign er_last     = er_off == `FBP_OFF_LAST;

    // Denied reads return zero, never the stored word
    assign rd_word = q_q.rd_ok ? arr.rdata : `FBP_RST_DATA;

    always_comb begin
        q_d         = q_q;
        q_d.rd_ack  = 1'b0;
        q_d.op_done = 1'b0;
        rd_gnt      = 1'b0;
        pg_gnt      = 1'b0;
        er_gnt      = 1'b0;
        arr.ren     = 1'b0;
        arr.raddr   = q_q.addr;
        arr.wen     = 1'b0;
        arr.waddr   = q_q.addr;
        arr.wdata   = `FBP_ERASED_WORD;
        case (q_q.st)
            fbp_pkg::FBP_ST_IDLE: begin
                // Reads first: fetch latency matters most
                if (rd_req) begin
                    rd_gnt      = 1'b1;
                    q_d.addr    = rd_addr;
                    q_d.rd_ok   = rd_ok;
                    arr.ren     = rd_ok;
                    arr.raddr   = rd_addr;
                    q_d.st      = fbp_pkg::FBP_ST_READ;
                end else if (pg_req) begin
                    pg_gnt = 1'b1;
                    if (pg_ok) begin
                        arr.ren   = 1'b1;
                        arr.raddr = pg_addr;
                        q_d.addr  = pg_addr;
                        q_d.data  = pg_data;
                        q_d.st    = fbp_pkg::FBP_ST_PROG;
                    end else begin
                        q_d.op_done = 1'b1;
                        q_d.op_err  = 1'b1;
                    end
                end else if (er_req) begin
                    // Erase last; once started it holds off reads for a whole block
                    er_gnt = 1'b1;
                    if (er_ok) begin
                        q_d.addr = {er_block, {`FBP_OFF_W{1'b0}}};
                        q_d.st   = fbp_pkg::FBP_ST_ERASE;
                    end else begin
                        q_d.op_done = 1'b1;
                        q_d.op_err  = 1'b1;
                    end
                end
            end
            fbp_pkg::FBP_ST_READ: begin
                // Answer pulses for one cycle in the next cycle; data stands from then on
                q_d.rd_ack  = 1'b1;
                q_d.rd_err  = !q_q.rd_ok;
                q_d.rd_data = rd_word;
                q_d.st      = fbp_pkg::FBP_ST_IDLE;
            end
            fbp_pkg::FBP_ST_PROG: begin
                // Programming only clears bits, as the cells allow
                arr.wen     = 1'b1;
                arr.wdata   = arr.rdata & q_q.data;
                q_d.op_done = 1'b1;
                q_d.op_err  = 1'b0;
                q_d.st      = fbp_pkg::FBP_ST_IDLE;
            end
            fbp_pkg::FBP_ST_ERASE: begin
                // One word per cycle; the block field never advances
                arr.wen   = 1'b1;
                arr.wdata = `FBP_ERASED_WORD;
                q_d.addr  = {q_q.addr[`FBP_AW-1:`FBP_BLK_LSB], er_off_next};
                if (er_last) begin
                    q_d.op_done = 1'b1;
                    q_d.op_err  = 1'b0;
                    q_d.st      = fbp_pkg::FBP_ST_IDLE;
                end
            end
            default: begin
                q_d = RST_Q;
            end
        endcase
    end

    // Only control state resets; the array keeps its contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_q <= RST_Q;
        end else begin
            q_q <= q_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_ack     = q_q.rd_ack;
    assign rd_denied  = q_q.rd_err;
    assign rd_data    = q_q.rd_data;
    assign op_done    = q_q.op_done;
    assign op_refused = q_q.op_err;
    assign busy       = q_q.st != fbp_pkg::FBP_ST_IDLE;

endmodule

//--- hdl/fbp_pkg.sv
// Types for the flash block erase and protection controller
`include "fbp_consts.svh"

package fbp_pkg;

    // ------------------------------------------------------------
    // Requester of a read
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBP_SRC_FETCH = 2'h0,
        FBP_SRC_DATA  = 2'h1,
        FBP_SRC_DEBUG = 2'h2
    } fbp_src_t;

    // ------------------------------------------------------------
    // Sequencer states, Gray along idle-read and idle-program
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBP_ST_IDLE  = 2'h0,
        FBP_ST_READ  = 2'h1,
        FBP_ST_PROG  = 2'h2,
        FBP_ST_ERASE = 2'h3
    } fbp_state_t;

    // ------------------------------------------------------------
    // Whole controller state
    // ------------------------------------------------------------
    typedef struct packed {
        fbp_state_t              st;
        logic [`FBP_AW-1:0]      addr;
        logic [`FBP_DW-1:0]      data;
        logic                    rd_ok;
        logic                    rd_ack;
        logic                    rd_err;
        logic [`FBP_DW-1:0]      rd_data;
        logic                    op_done;
        logic                    op_err;
    } fbp_ctrl_t;

endpackage

//--- test/fbp_ctrl_monitor.sv
// Port checker of the flash sequencer
`timescale 1ns/1ps
`include "fbp_consts.svh"

module fbp_ctrl_monitor #(
    parameter int unsigned N_UNITS = `FBP_UNITS
) (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // Read side
    input wire fbp_pkg::fbp_src_t     rd_src,
    input wire logic [`FBP_AW-1:0]    rd_addr,
    input wire logic                  rd_gnt,
    input wire logic                  rd_ack,
    input wire logic                  rd_denied,
    input wire logic [`FBP_DW-1:0]    rd_data,
    // Program, erase and protection
    input wire logic [`FBP_AW-1:0]    pg_addr,
    input wire logic                  pg_gnt,
    input wire logic [`FBP_BLK_W-1:0] er_block,
    input wire logic                  er_gnt,
    input wire logic                  op_done,
    input wire logic                  op_refused,
    input wire logic                  busy,
    input wire logic [N_UNITS-1:0]    prot_ro,
    input wire logic [N_UNITS-1:0]    prot_xo
);
    // Range test first, so an index past the last unit is never used
    wire logic [N_UNITS-1:0] lock  = prot_ro | prot_xo;
    wire logic               pg_ok = (pg_addr < 15'h6000) && !lock[pg_addr[14:9]];
    wire logic               er_ok = (er_block < 7'h60) && !lock[er_block[6:1]];
    wire logic               rd_ok = (rd_addr < 15'h6000)
        && (rd_src == fbp_pkg::FBP_SRC_FETCH || !prot_xo[rd_addr[14:9]]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RD_ANSWER: assert property (rd_gnt |=> !rd_ack ##1 rd_ack)
        else $error("read answer not in second cycle");
    AST_RD_SERVED: assert property (rd_gnt && rd_ok |-> ##2 rd_ack && !rd_denied)
        else $error("allowed read denied");
    AST_RD_DENIED: assert property (rd_gnt && !rd_ok |-> ##2 rd_denied && rd_data == 32'h0)
        else $error("execute-only read served");
    AST_PG_REFUSE: assert property (pg_gnt && !pg_ok |=> op_done && op_refused)
        else $error("protected program not refused");
    AST_PG_DONE: assert property (pg_gnt && pg_ok |=> busy ##1 op_done && !op_refused)
        else $error("program not done");
    AST_ER_REFUSE: assert property (er_gnt && !er_ok |=> op_done && op_refused)
        else $error("protected erase not refused");
    AST_ER_BUSY: assert property (er_gnt && er_ok |=> busy [*8])
        else $error("erase not busy");
    AST_ER_DONE: assert property (er_gnt && er_ok |-> ##257 op_done && !op_refused)
        else $error("erase length wrong");
    AST_GNT_IDLE: assert property (rd_gnt || pg_gnt || er_gnt |-> !busy)
        else $error("grant while busy");
endmodule

bind fbp_ctrl fbp_ctrl_monitor #(.N_UNITS(N_UNITS)) mon_u (.clk(clk), .rst(rst),
    .rd_src(rd_src), .rd_addr(rd_addr), .rd_gnt(rd_gnt), .rd_ack(rd_ack),
    .rd_denied(rd_denied), .rd_data(rd_data), .pg_addr(pg_addr), .pg_gnt(pg_gnt),
    .er_block(er_block), .er_gnt(er_gnt), .op_done(op_done), .op_refused(op_refused),
    .busy(busy), .prot_ro(prot_ro), .prot_xo(prot_xo));

//--- test/fbp_req_model.sv
// Read requester model: fetch, data and debug paths
`timescale 1ns/1ps
`include "fbp_consts.svh"

module fbp_req_model (
    // Clock and grant
    input wire logic              clk,
    input wire logic              rd_gnt,
    // Request
    output fbp_pkg::fbp_src_t     rd_src,
    output logic                  rd_req,
    output logic [`FBP_AW-1:0]    rd_addr
);
    initial begin
        rd_req  = 1'b0;
        rd_src  = fbp_pkg::FBP_SRC_FETCH;
        rd_addr = 15'h0;
    end

    // Released address shows the inverse, never the last value
    task automatic read(input fbp_pkg::fbp_src_t s, input logic [14:0] a, input int slow);
        repeat (slow + 1) @(posedge clk);
        #1 rd_req = 1'b1;
        rd_src  = s;
        rd_addr = a;
        do @(negedge clk); while (rd_gnt !== 1'b1);
        @(posedge clk) #1 rd_req = 1'b0;
        rd_addr = ~a;
    endtask
endmodule

//--- test/tb_flash_block_erase_protect.sv
// Self-checking bench of the flash sequencer
`timescale 1ns/1ps
`include "fbp_consts.svh"

module tb_flash_block_erase_protect;
    logic               clk, rst, pg_req, er_req;
    logic [14:0]        pg_addr;
    logic [31:0]        pg_data, d;
    logic [6:0]         er_block;
    logic [47:0]        prot_ro, prot_xo;
    logic [31:0]        sh [int];
    wire logic          rd_req, rd_gnt, rd_ack, rd_denied, pg_gnt, er_gnt, op_done, op_refused, busy;
    wire logic [14:0]   rd_addr;
    wire logic [31:0]   rd_data;
    fbp_pkg::fbp_src_t  rd_src;
    fbp_pkg::fbp_src_t  rs;
    logic [14:0]        ra;
    int                 bad_count, total_checks, cycles;
    integer             seed = 32'h328d;

    fbp_req_model req_u (.clk(clk), .rd_gnt(rd_gnt), .rd_src(rd_src), .rd_req(rd_req),
        .rd_addr(rd_addr));
    fbp_ctrl dut_u (.clk(clk), .rst(rst), .rd_req(rd_req), .rd_src(rd_src), .rd_addr(rd_addr),
        .rd_gnt(rd_gnt), .rd_ack(rd_ack), .rd_denied(rd_denied), .rd_data(rd_data),
        .pg_req(pg_req), .pg_addr(pg_addr), .pg_data(pg_data), .pg_gnt(pg_gnt),
        .er_req(er_req), .er_block(er_block), .er_gnt(er_gnt), .op_done(op_done),
        .op_refused(op_refused), .busy(busy), .prot_ro(prot_ro), .prot_xo(prot_xo));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    // Expected outcomes from the protection marks and the end of the array
    function automatic logic exp_deny(input fbp_pkg::fbp_src_t s, input logic [14:0] a);
        exp_deny = a >= 15'h6000 || (prot_xo[a[14:9]] && s != fbp_pkg::FBP_SRC_FETCH);
    endfunction

    function automatic logic exp_refuse(input logic [14:0] a);
        exp_refuse = a >= 15'h6000 || prot_ro[a[14:9]] || prot_xo[a[14:9]];
    endfunction

    task automatic rdchk(input fbp_pkg::fbp_src_t s, input logic [14:0] a, input logic den);
        req_u.read(s, a, int'($unsigned($random(seed)) % 3));
        @(posedge clk) #1;
        chk("rd_ack", 32'h1, {31'h0, rd_ack});
        chk("rd_denied", {31'h0, den}, {31'h0, rd_denied});
        chk("rd_data", den ? 32'h0 : sh[int'(a)], rd_data);
    endtask

    task automatic op(input logic er, input logic [14:0] a, input logic [31:0] dv, input logic r);
        int n;
        n = 0;
        @(posedge clk) #1;
        if (er) begin
            er_req   = 1'b1;
            er_block = a[14:8];
        end else begin
            pg_req  = 1'b1;
            pg_addr = a;
            pg_data = dv;
        end
        do @(negedge clk); while ((er ? er_gnt : pg_gnt) !== 1'b1);
        @(posedge clk) #1 {er_req, pg_req} = 2'h0;
        {er_block, pg_addr, pg_data} = ~{er_block, pg_addr, pg_data};
        while (op_done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk("op_done", 32'h1, {31'h0, op_done});
        chk("op_refused", {31'h0, r}, {31'h0, op_refused});
        if (!r && er) for (int i = 0; i < 256; i++) sh[int'({a[14:8], i[7:0]})] = 32'hffffffff;
        if (!r && !er) sh[int'(a)] = sh[int'(a)] & dv;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, pg_req, er_req, pg_addr, pg_data, er_block, prot_ro, prot_xo} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 4; i++) op(1'b1, {7'd2 + 7'(i), 8'h0}, 32'h0, 1'b0);
        op(1'b1, 15'h5f00, 32'h0, 1'b0);
        for (int i = 0; i < 8; i++)
            rdchk(fbp_pkg::fbp_src_t'($unsigned($random(seed)) % 3),
                {7'd2 + 7'(i % 3), 8'($random(seed))}, 1'b0);
        rdchk(fbp_pkg::FBP_SRC_DEBUG, 15'h5fff, 1'b0);
        d = $random(seed);
        op(1'b0, 15'h0210, d, 1'b0);
        op(1'b0, 15'h0433, $random(seed), 1'b0);
        op(1'b1, 15'h0300, 32'h0, 1'b0);
        rdchk(fbp_pkg::FBP_SRC_DATA, 15'h0210, 1'b0);
        // Units 0 to 2 fixed (0 open, 1 read-only, 2 execute-only), the rest random
        prot_ro = (48'({$random(seed), $random(seed)}) & 48'hfffffffffff8) | 48'h2;
        prot_xo = (48'({$random(seed), $random(seed)}) & 48'hfffffffffff8) | 48'h4;
        for (int k = 0; k < 2; k++) begin
            op(1'b1, k ? 15'h0400 : 15'h0200, 32'h0, 1'b1);
            op(1'b0, k ? 15'h0433 : 15'h0210, 32'h0, 1'b1);
            op(1'b1, k ? 15'h0500 : 15'h0300, 32'h0, 1'b1);
        end
        rdchk(fbp_pkg::FBP_SRC_DEBUG, 15'h05a0, 1'b1);
        // Random reads in units 1 and 2, random erases under the random marks
        for (int i = 0; i < 6; i++) begin
            rs = fbp_pkg::fbp_src_t'($unsigned($random(seed)) % 3);
            ra = {7'd2 + 7'($unsigned($random(seed)) % 4), 8'($random(seed))};
            rdchk(rs, ra, exp_deny(rs, ra));
            ra = {7'($unsigned($random(seed)) % 100), 8'h0};
            op(1'b1, ra, 32'h0, exp_refuse(ra));
        end
        rdchk(fbp_pkg::FBP_SRC_DATA, 15'h0210, 1'b0);
        rdchk(fbp_pkg::FBP_SRC_FETCH, 15'h0433, 1'b0);
        rdchk(fbp_pkg::FBP_SRC_DATA, 15'h0433, 1'b1);
        rdchk(fbp_pkg::FBP_SRC_DEBUG, 15'h0433, 1'b1);
        rdchk(fbp_pkg::FBP_SRC_DATA, 15'h6000, 1'b1);
        op(1'b1, 15'h0100, 32'h0, 1'b0);
        for (int s = 0; s < 3; s++)
            rdchk(fbp_pkg::fbp_src_t'(s), {7'd1, 8'($random(seed))}, 1'b0);
        complete_run();
    end
endmodule
